/* design/tcwsp_top.sv */
`timescale 1ns/10ps
// How it works
// RULE1: Sample divider output at Q2 and Q4
// RULE2: Undivided pin high and low two Tosc
// RULE3: Unowned divider: pin goes straight to sampler
// RULE4: Owned divider splits pin into symmetric wave
// RULE5: Divided pin period at least 4Tosc/ratio
// RULE6: Timer increments only after phase sampling; internal undivided count takes instr_tick unsampled
// RULE7: One 8-bit divider, prescaler or postscaler
// RULE8: Exactly one owner; other runs undivided
// RULE9: Owner bit and ratio from option bits
// RULE10: Timer write clears divider, keeps owner; the divider is cleared only while the timer owns it
// RULE11: Watchdog clear resets divider and watchdog; the divider is cleared only while the watchdog owns it
// RULE12: Divider count never readable nor loadable
// RULE13: Ownership may change any time by write
// RULE14: Timer to watchdog: clear, kick, then option
// RULE15: Watchdog to timer: kick, then option write
// RULE16: Source bit picks pin; edge bit picks edge
// RULE17: Overflow sets flag; enable gates interrupt
// RULE18: Undivided internal count; write pauses two cycles
// RULE19: Timer ratios 1:2 through 1:256
// RULE20: Ratio code n divides by two to n+1
module tcwsp_top import tcwsp_pkg::*; #(
  parameter int ADDR_W = 10,
  parameter int WDT_W = WDT_WIDTH
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic external_count_input_in,
  input wire logic watchdog_tick_in,
  input wire logic watchdog_enable_in,
  output logic timer_irq_out,
  output logic watchdog_timeout_out,
  output logic [7:0] port_a_direction_out
);

  tcwsp_div_if #(.RW(RATIO_W)) div ();

  tcwsp_phase_type phase_r;
  tcwsp_phase_type phase_nxt;
  logic instr_tick;

  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [7:0] aw_idx_r;
  logic [7:0] aw_idx_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [7:0] w_data_r;
  logic [7:0] w_data_nxt;
  logic w_lane_r;
  logic w_lane_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic do_write;
  logic wr_hit;

  logic rvalid_r;
  logic rvalid_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [7:0] rd_val;
  logic rd_hit;
  logic [7:0] ar_idx;

  logic [7:0] timer_r;
  logic [7:0] timer_nxt;
  logic [7:0] interrupt_control_r;
  logic [7:0] interrupt_control_nxt;
  logic [7:0] option_r;
  logic [7:0] option_nxt;
  logic [7:0] porta_r;
  logic [7:0] porta_nxt;
  logic [1:0] inhibit_r;
  logic [1:0] inhibit_nxt;
  logic [WDT_W-1:0] wdt_cnt_r;
  logic [WDT_W-1:0] wdt_cnt_nxt;
  logic wdt_to_r;
  logic wdt_to_nxt;
  logic irq_r;
  logic irq_nxt;
  logic pin_prev_r;
  logic pin_prev_nxt;

  logic wr_timer;
  logic wr_wdt_clear;
  logic ext_mode;
  logic owner_wdt;
  logic pin_level;
  logic pin_rise;
  logic sync_level;
  logic sync_edge;
  logic timer_inc;
  logic overflow;

  // Instruction cycle phase sequencer
  always_comb begin
    case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
      default: phase_nxt = PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign instr_tick = (phase_r == PH_Q4);

  // Bus write: address and data taken in either order, answered after both
  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out = !w_hold_r && !bvalid_r;
  assign do_write = aw_hold_r && w_hold_r;

  always_comb begin
    case (aw_idx_r)
      IDX_TIMER_COUNT: wr_hit = 1'b1;
      IDX_INTERRUPT_CONTROL: wr_hit = 1'b1;
      IDX_OPTION_CONTROL: wr_hit = 1'b1;
      IDX_PORT_A_DIRECTION: wr_hit = 1'b1;
      IDX_WATCHDOG_COMMAND: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_idx_nxt = aw_idx_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr_in[9:2];
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata_in[7:0];
      w_lane_nxt = s_axi_wstrb_in[0];
    end
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready_in) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      aw_hold_r <= 1'b0;
      aw_idx_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;

  // Bus read; the divider count has no address at all [RULE12]
  assign s_axi_arready_out = !rvalid_r;
  assign ar_idx = s_axi_araddr_in[9:2];

  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_TIMER_COUNT: rd_val = timer_r;
      IDX_INTERRUPT_CONTROL: rd_val = interrupt_control_r;
      IDX_OPTION_CONTROL: rd_val = option_r;
      IDX_PORT_A_DIRECTION: rd_val = porta_r;
      IDX_WATCHDOG_COMMAND: rd_val = 8'h00;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_val;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = {24'h000000, rdata_r};
  assign s_axi_rresp_out = rresp_r;

  // Count path
  assign wr_timer = do_write && w_lane_r && (aw_idx_r == IDX_TIMER_COUNT);
  assign wr_wdt_clear = do_write && w_lane_r && (aw_idx_r == IDX_WATCHDOG_COMMAND)
    && w_data_r[CMD_WDT_CLEAR_BIT];
  assign ext_mode = option_r[OPT_SOURCE_BIT]; // [RULE16]
  assign owner_wdt = option_r[OPT_OWNER_BIT]; // [RULE9]
  // A set edge bit inverts the pin so that falling edges count [RULE16]
  assign pin_level = external_count_input_in ^ option_r[OPT_EDGE_BIT];
  assign pin_rise = pin_level && !pin_prev_r;

  assign div.owner_wdt = owner_wdt; // [RULE8]
  assign div.ratio = option_r[OPT_RATIO_LSB +: RATIO_W]; // [RULE9]
  assign div.tmr_event = !owner_wdt && (ext_mode ? pin_rise : instr_tick);
  assign div.wdt_event = watchdog_enable_in && watchdog_tick_in;
  // Clearing only the current owner's path keeps the other's count intact
  assign div.clear = (wr_timer && !owner_wdt) || (wr_wdt_clear && owner_wdt); // [RULE10] [RULE11]

  // Without the divider the pin bypasses it into the sampler [RULE3]
  assign sync_level = owner_wdt ? pin_level : div.tmr_level;

  tcwsp_prescaler #(.WIDTH(DIVIDER_WIDTH)) u_prescaler (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .div(div)
  );

  tcwsp_sync u_sync (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .phase_in(phase_r),
    .level_in(sync_level),
    .edge_out(sync_edge)
  );

  // Internal undivided counting skips the sampler, one step per cycle [RULE18]
  assign timer_inc = (ext_mode || !owner_wdt) ? sync_edge : instr_tick; // [RULE6]
  assign overflow = timer_inc && (inhibit_r == 2'b00) && (timer_r == 8'hFF);

  always_comb begin
    timer_nxt = timer_r;
    interrupt_control_nxt = interrupt_control_r;
    option_nxt = option_r;
    porta_nxt = porta_r;
    inhibit_nxt = inhibit_r;
    wdt_cnt_nxt = wdt_cnt_r;
    wdt_to_nxt = 1'b0;
    pin_prev_nxt = pin_level;
    if (instr_tick && (inhibit_r != 2'b00)) begin
      inhibit_nxt = inhibit_r - 2'b01;
    end
    if (timer_inc && (inhibit_r == 2'b00)) begin
      timer_nxt = timer_r + 8'h01;
    end
    if (do_write && w_lane_r) begin
      case (aw_idx_r)
        IDX_TIMER_COUNT: begin
          timer_nxt = w_data_r;
          inhibit_nxt = INHIBIT_LOAD; // [RULE18]
        end
        IDX_INTERRUPT_CONTROL: interrupt_control_nxt = w_data_r;
        IDX_OPTION_CONTROL: option_nxt = w_data_r; // [RULE13]
        IDX_PORT_A_DIRECTION: porta_nxt = w_data_r & PORT_A_DIRECTION_MASK;
        default: option_nxt = option_r;
      endcase
    end
    // A rollover in the clearing cycle still leaves the flag set [RULE17]
    if (overflow) begin
      interrupt_control_nxt[INT_FLAG_BIT] = 1'b1;
    end
    if (wr_wdt_clear) begin
      wdt_cnt_nxt = '0; // [RULE11]
    end else if (watchdog_enable_in && div.wdt_tick) begin
      wdt_cnt_nxt = wdt_cnt_r + WDT_W'(1);
      wdt_to_nxt = &wdt_cnt_r;
    end
    irq_nxt = interrupt_control_nxt[INT_FLAG_BIT] && interrupt_control_nxt[INT_ENABLE_BIT]; // [RULE17]
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      timer_r <= TIMER_COUNT_RST;
      interrupt_control_r <= INTERRUPT_CONTROL_RST;
      option_r <= OPTION_CONTROL_RST;
      porta_r <= PORT_A_DIRECTION_RST;
      inhibit_r <= 2'b00;
      wdt_cnt_r <= '0;
      wdt_to_r <= 1'b0;
      irq_r <= 1'b0;
      pin_prev_r <= pin_level;
    end else begin
      timer_r <= timer_nxt;
      interrupt_control_r <= interrupt_control_nxt;
      option_r <= option_nxt;
      porta_r <= porta_nxt;
      inhibit_r <= inhibit_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      wdt_to_r <= wdt_to_nxt;
      irq_r <= irq_nxt;
      pin_prev_r <= pin_prev_nxt;
    end
  end

  assign timer_irq_out = irq_r;
  assign watchdog_timeout_out = wdt_to_r;
  assign port_a_direction_out = porta_r;
endmodule

/* design/tcwsp_pkg.sv */
package tcwsp_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_OPTION_CONTROL = 8'h81;
  localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] IDX_WATCHDOG_COMMAND = 8'h90;

  // Reset values
  localparam logic [7:0] TIMER_COUNT_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] OPTION_CONTROL_RST = 8'hFF;
  localparam logic [7:0] PORT_A_DIRECTION_RST = 8'h1F;
  localparam logic [7:0] PORT_A_DIRECTION_MASK = 8'h1F;

  // Field positions
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  localparam int OPT_OWNER_BIT = 3;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_SOURCE_BIT = 5;
  localparam int INT_FLAG_BIT = 2;
  localparam int INT_ENABLE_BIT = 5;
  localparam int CMD_WDT_CLEAR_BIT = 0;

  // Widths
  localparam int DIVIDER_WIDTH = 8;
  localparam int WDT_WIDTH = 8;

  // Timing: one instruction cycle is four core clock phases
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_PERIOD_NS = 200;
  localparam int PHASES_PER_INSTR = INSTR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [1:0] INHIBIT_LOAD = 2'(INHIBIT_INSTR);

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } tcwsp_phase_type;

endpackage

/* design/tcwsp_div_if.sv */
`timescale 1ns/10ps
interface tcwsp_div_if #(
  parameter int RW = 3
);
  logic tmr_event;
  logic wdt_event;
  logic clear;
  logic owner_wdt;
  logic [RW-1:0] ratio;
  logic tmr_level;
  logic wdt_tick;

  modport ctrl (
    output tmr_event, wdt_event, clear, owner_wdt, ratio,
    input tmr_level, wdt_tick
  );
  modport div (
    input tmr_event, wdt_event, clear, owner_wdt, ratio,
    output tmr_level, wdt_tick
  );
endinterface

/* design/tcwsp_prescaler.sv */
`timescale 1ns/10ps
module tcwsp_prescaler import tcwsp_pkg::*; #(
  parameter int WIDTH = DIVIDER_WIDTH
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  tcwsp_div_if.div div
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic [WIDTH-1:0] mask;
  logic src_event;

  // One counter, clocked by whichever owner holds it [RULE7] [RULE8]
  always_comb begin
    src_event = div.owner_wdt ? div.wdt_event : div.tmr_event;
    cnt_nxt = cnt_r;
    if (div.clear) begin
      cnt_nxt = '0;
    end else if (src_event) begin
      cnt_nxt = cnt_r + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // A counter bit is a symmetric square wave, as a ripple stage gives [RULE4]
  // Code n selects bit n, so 000 divides by 2 and 111 by 256 [RULE20] [RULE19]
  assign div.tmr_level = div.owner_wdt ? 1'b0 : cnt_r[div.ratio];

  // Postscaler: undivided while the timer owns the counter [RULE8]
  always_comb begin
    mask = (WIDTH'(1) << div.ratio) - WIDTH'(1);
    if (div.owner_wdt) begin
      div.wdt_tick = div.wdt_event && ((cnt_r & mask) == mask);
    end else begin
      div.wdt_tick = div.wdt_event;
    end
  end
endmodule

/* design/tcwsp_sync.sv */
`timescale 1ns/10ps
module tcwsp_sync import tcwsp_pkg::*; (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire tcwsp_phase_type phase_in,
  input wire logic level_in,
  output logic edge_out
);
  logic stage_a_r;
  logic stage_a_nxt;
  logic stage_b_r;
  logic stage_b_nxt;
  logic stage_c_r;
  logic stage_c_nxt;
  logic edge_r;
  logic edge_nxt;

  // Sample at Q2, confirm at Q4; the edge costs up to two and a half instruction cycles [RULE1] [RULE6]
  always_comb begin
    stage_a_nxt = stage_a_r;
    stage_b_nxt = stage_b_r;
    stage_c_nxt = stage_c_r;
    edge_nxt = 1'b0;
    if (phase_in == PH_Q2) begin
      stage_a_nxt = level_in;
    end
    if (phase_in == PH_Q4) begin
      stage_b_nxt = stage_a_r;
      stage_c_nxt = stage_b_r;
      edge_nxt = stage_b_r && !stage_c_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      // Stages start at the pin's level, so leaving reset is never taken for an edge
      stage_a_r <= level_in;
      stage_b_r <= level_in;
      stage_c_r <= level_in;
      edge_r <= 1'b0;
    end else begin
      stage_a_r <= stage_a_nxt;
      stage_b_r <= stage_b_nxt;
      stage_c_r <= stage_c_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign edge_out = edge_r;
endmodule

/* sim/tcwsp_checker.sv */
`timescale 1ns/10ps
module tcwsp_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic external_count_input_in,
  input wire logic watchdog_tick_in,
  input wire logic watchdog_enable_in,
  input wire logic timer_irq_out,
  input wire logic watchdog_timeout_out,
  input wire logic [7:0] port_a_direction_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_wr_both;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  a_wr_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid_out)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while busy");
  a_w_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out &&
    !s_axi_wready_out) else $error("write taken while busy");
  a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_tmo_pulse: assert property (watchdog_timeout_out |=> !watchdog_timeout_out)
    else $error("timeout longer than a pulse");
  a_tmo_en: assert property (!watchdog_enable_in [*3] |-> !watchdog_timeout_out)
    else $error("timeout while disabled");
  a_tmo_tick: assert property (!watchdog_tick_in [*3] |-> !watchdog_timeout_out)
    else $error("timeout without tick");
endmodule
bind tcwsp_top tcwsp_checker #(.ADDR_W(ADDR_W)) i_tcwsp_checker (.*);

/* sim/tcwsp_ext_src.sv */
`timescale 1ns/10ps
module tcwsp_ext_src (
  input wire logic core_clk_in,
  input wire logic go_in,
  input int half_in,
  input int n_in,
  output logic pin_out,
  output logic busy_out
);
  initial pin_out = 1'h0;
  initial busy_out = 1'h0;
  // Pin idles low between bursts; each level held half_in clocks
  always begin
    @(posedge core_clk_in);
    if (go_in) begin
      busy_out <= 1'h1;
      repeat (n_in) begin
        pin_out <= 1'h1;
        repeat (half_in) @(posedge core_clk_in);
        pin_out <= 1'h0;
        repeat (half_in) @(posedge core_clk_in);
      end
      busy_out <= 1'h0;
    end
  end
endmodule

/* sim/test_timer_counter_with_shared_prescaler.sv */
`timescale 1ns/10ps
module test_timer_counter_with_shared_prescaler import tcwsp_pkg::*;;
  logic clk = 1'h0, nrst = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0;
  logic rre = 1'h0, tick = 1'h0, wen = 1'h0, go = 1'h0, lane0 = 1'h1;
  logic [3:0] sb = 4'hF;
  logic [9:0] aa = 10'h0, ra = 10'h0;
  logic [31:0] wd = 32'h0, rdat, rd_d;
  logic awr, wrd, bv, arr, rv, pin, busy, irq, tmo;
  logic [1:0] br, rr;
  logic [7:0] pa, d;
  int half = 4, npl = 0, fails = 0, n_tests = 0, seed = 79, cyc = 0, wcnt = 0, a, k;
  int mreg [int];
  int lst [6] = '{1, 11, 129, 133, 144, 64};
  always #25 clk = ~clk;
  tcwsp_top i_tcwsp_top (.core_clk_in(clk), .nrst_in(nrst),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(aa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(sb), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ra), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .external_count_input_in(pin),
    .watchdog_tick_in(tick), .watchdog_enable_in(wen), .timer_irq_out(irq),
    .watchdog_timeout_out(tmo), .port_a_direction_out(pa));
  tcwsp_ext_src i_tcwsp_ext_src (.core_clk_in(clk), .go_in(go), .half_in(half),
    .n_in(npl), .pin_out(pin), .busy_out(busy));
  // Watchdog ticks run every cycle while enabled; wcnt counts what was offered
  always @(posedge clk) begin
    tick <= wen;
    if (tick)
      wcnt <= wcnt + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge clk);
    awv <= 1'h1;
    wv <= 1'h1;
    bre <= 1'h1;
    aa <= {i, 2'h0};
    wd <= {24'h0, v};
    sb <= {3'h7, lane0};
    do begin
      @(posedge clk);
      if (awv && awr)
        awv <= 1'h0;
      if (wv && wrd)
        wv <= 1'h0;
    end while (!bv);
    bre <= 1'h0;
    chk("bresp", mreg.exists(i) ? RESP_OKAY : RESP_SLVERR, br);
    if (mreg.exists(i) && lane0)
      mreg[i] = (i == 8'h85) ? (v & 8'h1F) : (i == 8'h90) ? 0 : v;
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge clk);
    arv <= 1'h1;
    rre <= 1'h1;
    ra <= {i, 2'h0};
    do begin
      @(posedge clk);
      if (arv && arr)
        arv <= 1'h0;
    end while (!rv);
    rd_d = rdat;
    rre <= 1'h0;
    chk("rresp", mreg.exists(i) ? RESP_OKAY : RESP_SLVERR, rr);
  endtask
  task automatic pulses(input int n, input int h);
    npl = n;
    half = h;
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    do @(posedge clk); while (busy);
    repeat (16) @(posedge clk);
  endtask
  initial begin
    mreg[1] = 0;
    mreg[11] = 0;
    mreg[129] = 255;
    mreg[133] = 31;
    mreg[144] = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    foreach (lst[j]) begin
      rd(lst[j]);
      chk("reset value", mreg.exists(lst[j]) ? mreg[lst[j]] : 0, rd_d);
    end
    // Idle pin after reset: no edge may have been counted
    rd(8'h01);
    chk("idle timer", mreg[1], rd_d);
    chk("port_a", 8'h1F, pa);
    d = $random(seed);
    wr(8'h85, d);
    // Lane 0 strobe low: the write is answered but ignored
    lane0 = 1'h0;
    wr(8'h85, ~d);
    lane0 = 1'h1;
    rd(8'h85);
    chk("port_a read", mreg[133], rd_d);
    chk("port_a pins", d & 8'h1F, pa);
    $display("test registers done");
    // Internal count, watchdog owns divider: write pauses two cycles
    wr(8'h81, 8'h08);
    wr(8'h01, 8'h00);
    repeat (20) @(posedge clk);
    rd(8'h01);
    a = rd_d;
    chk("pause", 1, a >= 2 && a <= 4);
    repeat (37) @(posedge clk);
    rd(8'h01);
    chk("rate", a + 10, rd_d);
    wr(8'h0B, 8'h20);
    wr(8'h01, 8'hFE);
    for (k = 0; k < 60 && !irq; k++) @(posedge clk);
    chk("irq", 1, irq);
    rd(8'h0B);
    chk("flag", 8'h24, rd_d);
    wr(8'h0B, 8'h00);
    wr(8'h01, 8'hFE);
    repeat (60) @(posedge clk);
    chk("masked irq", 0, irq);
    rd(8'h0B);
    chk("flag only", 8'h04, rd_d);
    $display("test internal done");
    // External pin, both edges undivided, then rising edges divided 1:2 to 1:8
    for (int e = 0; e < 2; e++) begin
      wr(8'h81, 8'h28 | (e << 4));
      repeat (12) @(posedge clk);
      wr(8'h01, 8'h00);
      repeat (12) @(posedge clk);
      k = 1 + ($random(seed) & 7);
      pulses(k, 4);
      rd(8'h01);
      chk("pin count", k, rd_d);
    end
    wr(8'h90, 8'h01);
    for (int r = 0; r < 3; r++) begin
      wr(8'h81, 8'h20 | r);
      repeat (12) @(posedge clk);
      wr(8'h01, 8'h00);
      repeat (12) @(posedge clk);
      k = 1 + ($random(seed) & 3);
      pulses(k << (r + 1), 2);
      rd(8'h01);
      chk("divided count", k, rd_d);
    end
    // Internal count through the divider at 1:2
    wr(8'h81, 8'h00);
    repeat (40) @(posedge clk);
    rd(8'h01);
    a = rd_d;
    repeat (61) @(posedge clk);
    rd(8'h01);
    chk("prescaled rate", a + 8, rd_d);
    wr(8'h01, 8'h00);
    wr(8'h90, 8'h01);
    wr(8'h81, 8'h08);
    $display("test external done");
    // Watchdog kick mid-count restarts the full count
    wen <= 1'h1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (tmo === 1'h1)
        chk("early timeout", 0, 1);
    end
    wen <= 1'h0;
    repeat (3) @(posedge clk);
    wr(8'h90, 8'h01);
    a = wcnt;
    wen <= 1'h1;
    for (k = 0; k < 400 && tmo !== 1'h1; k++) @(posedge clk);
    chk("kick span", 1, wcnt - a >= 256 && wcnt - a <= 259);
    wen <= 1'h0;
    // Watchdog owning the divider at code 1 needs two offered ticks per step
    repeat (3) @(posedge clk);
    wr(8'h81, 8'h09);
    wr(8'h90, 8'h01);
    a = wcnt;
    wen <= 1'h1;
    for (k = 0; k < 700 && tmo !== 1'h1; k++) @(posedge clk);
    chk("postscale span", 1, wcnt - a >= 512 && wcnt - a <= 515);
    wen <= 1'h0;
    $display("test watchdog done");
    final_report;
  end
endmodule
